// ==== pkg/uart_de_irq_consts.vh ====
// register offsets, field positions and reset values for the uart block
`ifndef UART_DE_IRQ_CONSTS_VH
`define UART_DE_IRQ_CONSTS_VH
`define ADDR_TXD        4'h0
`define ADDR_RXD        4'h1
`define ADDR_STAT0      4'h2
`define ADDR_CTL0       4'h3
`define ADDR_CTL1       4'h4
`define ADDR_BRG        4'h5
`define ADDR_STAT1      4'h6
// control 0 fields
`define CTL0_TXEN       0
`define CTL0_RXEN       1
`define CTL0_PAREN      2
`define CTL0_STOP2      3
// control 1 fields
`define CTL1_MULTIPROCESSOR_ENABLE       0
`define CTL1_MPMD       1
`define CTL1_DRIVE_ENABLE_POLARITY      2
`define CTL1_RDAIRQ_DIS 3
`define CTL1_BRGIRQ_EN  4
// status 0 fields
`define ST0_RDA         0
`define ST0_PE          1
`define ST0_OE          2
`define ST0_FE          3
`define ST0_BREAK_DETECTED        4
`define ST0_TX_HOLDING_EMPTY        5
`define ST0_TXE         6
`define ST0_MPRX        7
// reset values and bus response codes
`define CTL0_RST        4'h0
`define CTL1_RST        5'h00
`define BRG_RST         16'h0004
`define ZERO32          32'h0000_0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// ==== rtl/uart_driver_enable_and_irq.v ====
// uart transmitter with driver enable, interrupt sources and receive overrun handling
`timescale 1ns/10ps
`include "uart_de_irq_consts.vh"

// Overview of operation
// - drive enable covers whole frame, parity and stop bits, active high by default
// - writing transmit data asserts drive enable
// - drive enable leads start bit by between one and two bit periods
// - drive enable drops one clock after the last stop bit
// - back to back characters keep drive enable asserted between them
// - polarity bit in control 1 inverts drive enable level
// - separate transmitter and receiver interrupt outputs
// - with transmitter and receiver off the baud generator acts as a timer interrupt
// - holding-empty flag and tx interrupt set once the first bit is shifted
// - writing transmit data clears holding-empty flag
// - rx interrupt on data, break, overrun or framing error; data source maskable
// - data interrupt after a full character lands in receive data, or after the read that shows an overrun
// - multiprocessor mode gates data interrupts by mode and last address byte
// - overrun keeps the valid byte in receive data
// - overrun and break status hidden until the valid byte is read
// - after that read overrun shows and data-available sets, byte invalid
// - break flag tells whether the overrun came from a break
// - a second receive data read clears the error bits
// - receive data reloads only when the next complete word arrives
module uart_driver_enable_and_irq #(
  parameter ADDR_W = 4
)(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rxd,
  output reg         txd,
  output reg         transceiver_drive_enable,
  output reg         tx_irq,
  output reg         rx_irq
);

  // register state
  reg  [3:0]  ctl0;
  reg  [4:0]  ctl1;
  reg  [15:0] brg;
  reg  [7:0]  tx_hold;
  reg         tx_holding_empty;
  reg  [7:0]  rx_data;
  reg         rx_data_available;
  reg         parity_err;
  reg         frame_err;
  reg         overrun_pend;
  reg         break_pend;
  reg         overrun_shown;
  reg         break_detected;
  reg         mp_addr_rx;
  reg         mp_match;
  reg  [7:0]  mp_addr;

  // write channel capture
  reg         aw_got;
  reg         w_got;
  reg  [ADDR_W-1:0] waddr;
  reg  [31:0] wdata;
  reg         wstrb0;
  wire        wdata_lane0 = wstrb0;
  wire        wr_fire = aw_got & w_got & ~s_axi_bvalid;
  wire        wr_txd  = wr_fire & (waddr == `ADDR_TXD) & wdata_lane0;
  wire        rd_fire = s_axi_arvalid & s_axi_arready;
  wire [ADDR_W-1:0] raddr = s_axi_araddr[ADDR_W+1:2];
  wire        rd_rxd  = rd_fire & (raddr == `ADDR_RXD);
  wire        multiprocessor_enable = ctl1[`CTL1_MULTIPROCESSOR_ENABLE];
  wire        drive_enable_polarity = ctl1[`CTL1_DRIVE_ENABLE_POLARITY];
  wire        w_mapped = (waddr <= `ADDR_BRG) && (waddr != `ADDR_RXD)
                         && (waddr != `ADDR_STAT0);

  // axi write address and data, taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      waddr         <= {ADDR_W{1'b0}};
      wdata         <= `ZERO32;
      wstrb0        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got        <= 1'b1;
        waddr         <= s_axi_awaddr[ADDR_W+1:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got        <= 1'b1;
        wdata        <= s_axi_wdata;
        wstrb0       <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl0 <= `CTL0_RST;
      ctl1 <= `CTL1_RST;
      brg  <= `BRG_RST;
    end
    else if (wr_fire && wstrb0)
    begin
      if (waddr == `ADDR_CTL0)
        ctl0 <= wdata[3:0];
      if (waddr == `ADDR_CTL1)
        ctl1 <= wdata[4:0];
      if (waddr == `ADDR_BRG)
        brg  <= wdata[15:0];
    end
  end

  // baud tick, sixteen per bit; free running also serves as timer
  reg  [15:0] brg_cnt;
  reg         bit_tick;
  reg         brg_tick;
  reg  [3:0]  os_cnt;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brg_cnt  <= 16'h0000;
      brg_tick <= 1'b0;
      os_cnt   <= 4'h0;
      bit_tick <= 1'b0;
    end
    else
    begin
      brg_tick <= 1'b0;
      bit_tick <= 1'b0;
      if (brg_cnt >= brg - 16'h0001)
      begin
        brg_cnt  <= 16'h0000;
        brg_tick <= 1'b1;
        os_cnt   <= os_cnt + 4'h1;
        bit_tick <= (os_cnt == 4'hf);
      end
      else
        brg_cnt <= brg_cnt + 16'h0001;
    end
  end

  // transmitter: lead bit with drive enable, then start, data, parity, stops
  localparam TX_IDLE  = 5'b00001;
  localparam TX_LEAD  = 5'b00010;
  localparam TX_START = 5'b00100;
  localparam TX_DATA  = 5'b01000;
  localparam TX_STOP  = 5'b10000;
  reg  [4:0]  tx_state;
  reg  [7:0]  tx_shift;
  reg  [2:0]  tx_bit;
  reg         tx_par;
  reg         tx_parbit;
  reg  [1:0]  tx_stops;
  reg         de_act;
  reg         tx_lead_seen;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state         <= TX_IDLE;
      tx_shift         <= 8'h00;
      tx_bit           <= 3'h0;
      tx_par           <= 1'b0;
      tx_parbit        <= 1'b0;
      tx_stops         <= 2'h0;
      tx_hold          <= 8'h00;
      tx_holding_empty <= 1'b1;
      txd              <= 1'b1;
      de_act           <= 1'b0;
      tx_lead_seen     <= 1'b0;
    end
    else
    begin
      if (wr_txd)
      begin
        tx_hold          <= wdata[7:0];
        tx_holding_empty <= 1'b0;
      end
      case (tx_state)
        TX_IDLE:
        begin
          de_act       <= 1'b0;
          tx_lead_seen <= 1'b0;
          if (!tx_holding_empty && ctl0[`CTL0_TXEN])
          begin
            de_act   <= 1'b1;
            tx_state <= TX_LEAD;
          end
        end
        TX_LEAD:
          if (bit_tick)
          begin
            // first tick aligns, second closes one full bit of lead
            tx_lead_seen <= 1'b1;
            if (tx_lead_seen)
            begin
              tx_shift <= tx_hold;
              txd      <= 1'b0;
              tx_state <= TX_START;
            end
          end
        TX_START:
          if (bit_tick)
          begin
            txd      <= tx_shift[0];
            tx_par   <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= 3'h0;
            if (!wr_txd)
              tx_holding_empty <= 1'b1;
            tx_state <= TX_DATA;
          end
        TX_DATA:
          if (bit_tick)
          begin
            if (tx_bit == 3'h7)
            begin
              if (ctl0[`CTL0_PAREN] && !tx_parbit)
              begin
                txd       <= tx_par;
                tx_parbit <= 1'b1;
              end
              else
              begin
                txd       <= 1'b1;
                tx_parbit <= 1'b0;
                tx_stops  <= ctl0[`CTL0_STOP2] ? 2'h2 : 2'h1;
                tx_state  <= TX_STOP;
              end
            end
            else
            begin
              txd      <= tx_shift[0];
              tx_par   <= tx_par ^ tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit   <= tx_bit + 3'h1;
            end
          end
        TX_STOP:
          if (bit_tick)
          begin
            if (tx_stops == 2'h2)
              tx_stops <= 2'h1;
            else if (!tx_holding_empty || wr_txd)
            begin
              tx_shift         <= wr_txd ? wdata[7:0] : tx_hold;
              txd              <= 1'b0;
              tx_state         <= TX_START;
            end
            else
            begin
              de_act   <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // drive enable output with polarity select
  always @(posedge aclk)
  begin
    if (!aresetn)
      transceiver_drive_enable <= 1'b0;
    else
      transceiver_drive_enable <= de_act ^ drive_enable_polarity;
  end

  // receive pin synchroniser: three stages, change once last two agree
  reg  [2:0]  rx_sync;
  reg         rx_in;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sync <= 3'b111;
      rx_in   <= 1'b1;
    end
    else
    begin
      rx_sync <= {rx_sync[1:0], rxd};
      if (rx_sync[1] == rx_sync[2])
        rx_in <= rx_sync[2];
    end
  end

  // receiver: sample mid bit, then deliver or flag overrun
  reg         rx_busy;
  reg  [3:0]  rx_os;
  reg  [3:0]  rx_bit;
  reg  [9:0]  rx_sh;
  reg         rx_done;
  reg         rx_prev;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_prev <= 1'b1;
      rx_busy <= 1'b0;
      rx_os   <= 4'h0;
      rx_bit  <= 4'h0;
      rx_sh   <= 10'h000;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      rx_prev <= rx_in;
      // start only on a falling edge, so a low stop bit cannot restart
      if (!rx_busy)
      begin
        if (rx_prev && !rx_in && ctl0[`CTL0_RXEN])
        begin
          rx_busy <= 1'b1;
          rx_os   <= 4'h0;
          rx_bit  <= 4'h0;
        end
      end
      else if (brg_tick)
      begin
        rx_os <= rx_os + 4'h1;
        if (rx_os == 4'h7)
        begin
          rx_sh  <= {rx_in, rx_sh[9:1]};
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == (ctl0[`CTL0_PAREN] ? 4'ha : 4'h9))
          begin
            rx_busy <= 1'b0;
            rx_done <= 1'b1;
          end
        end
      end
    end
  end

  // received frame fields
  wire [7:0] fr_data  = ctl0[`CTL0_PAREN] ? rx_sh[7:0] : rx_sh[8:1];
  wire       fr_par   = rx_sh[8];
  wire       fr_stop  = rx_sh[9];
  wire       fr_brk   = (fr_data == 8'h00) && !fr_stop;
  wire       fr_perr  = ctl0[`CTL0_PAREN] && ((^fr_data) != fr_par);
  wire       fr_is_addr = multiprocessor_enable && fr_perr;
  wire       fr_keep  = !multiprocessor_enable || fr_is_addr || mp_match
                        || !ctl1[`CTL1_MPMD];

  // receive data and status sequencing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data           <= 8'h00;
      rx_data_available <= 1'b0;
      parity_err        <= 1'b0;
      frame_err         <= 1'b0;
      overrun_pend      <= 1'b0;
      break_pend        <= 1'b0;
      overrun_shown     <= 1'b0;
      break_detected    <= 1'b0;
      mp_addr_rx        <= 1'b0;
      mp_match          <= 1'b0;
      mp_addr           <= 8'h00;
    end
    else
    begin
      if (rd_rxd)
      begin
        rx_data_available <= 1'b0;
        parity_err        <= 1'b0;                               // read consumes the errors
        frame_err         <= 1'b0;
        if (overrun_shown)
        begin
          overrun_shown  <= 1'b0;
          break_detected <= 1'b0;
        end
        else if (overrun_pend)
        begin
          overrun_shown     <= 1'b1;
          break_detected    <= break_pend;
          rx_data_available <= 1'b1;
          overrun_pend      <= 1'b0;
          break_pend        <= 1'b0;
        end
      end
      if (rx_done && fr_keep)
      begin
        if (rx_data_available && !rd_rxd || overrun_shown)
        begin
          overrun_pend <= 1'b1;
          if (fr_brk)
            break_pend <= 1'b1;
        end
        else
        begin
          rx_data           <= fr_data;
          rx_data_available <= 1'b1;
          parity_err        <= fr_perr & !multiprocessor_enable;
          frame_err         <= !fr_stop;
          mp_addr_rx        <= fr_is_addr;
          if (fr_is_addr)
          begin
            mp_addr  <= fr_data;
            mp_match <= 1'b1;
          end
        end
      end
    end
  end

  // interrupt outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= (ctl0[`CTL0_TXEN] & tx_holding_empty)
                | (~ctl0[`CTL0_TXEN] & ~ctl0[`CTL0_RXEN]
                   & ctl1[`CTL1_BRGIRQ_EN] & brg_tick);
      rx_irq <= (rx_data_available & ~ctl1[`CTL1_RDAIRQ_DIS]
                 & (~multiprocessor_enable | mp_match))
                | overrun_shown | break_detected | frame_err;
    end
  end

  // read channel
  reg  [31:0] rd_mux;
  always @*
  begin
    rd_mux = `ZERO32;
    case (raddr)
      `ADDR_TXD:   rd_mux = {24'h000000, tx_hold};
      `ADDR_RXD:   rd_mux = {24'h000000, rx_data};
      `ADDR_STAT0: rd_mux = {24'h000000, mp_addr_rx, ~de_act, tx_holding_empty,
                             break_detected, frame_err, overrun_shown,
                             parity_err, rx_data_available};
      `ADDR_CTL0:  rd_mux = {28'h0000000, ctl0};
      `ADDR_CTL1:  rd_mux = {27'h0000000, ctl1};
      `ADDR_BRG:   rd_mux = {16'h0000, brg};
      `ADDR_STAT1: rd_mux = {24'h000000, mp_addr};
      default:     rd_mux = `ZERO32;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `ZERO32;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (raddr <= `ADDR_STAT1) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== verification/line_partner.sv ====
// bus transceiver model: sends frames on rxd, captures frames framed by drive enable
`timescale 1ns/10ps
module line_partner #(
  parameter BIT_CLKS = 64
)(
  input  wire aclk,
  input  wire txd,
  input  wire de_act,
  output reg  rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rxd = 1'b1; // biased bus idles high

  // one frame: start, 8 bits lsb first, optional parity, chosen stop level, idle bit
  task automatic send(input logic [7:0] b, input logic par_on, input logic par, input logic stp);
    for (int i = -1; i < 10; i++)
    begin
      if (i == 8 && !par_on)
        continue;
      rxd <= (i < 0) ? 1'b0 : (i < 8) ? b[i] : (i == 8) ? par : stp;
      repeat (BIT_CLKS) @(posedge aclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge aclk);
  endtask

  // sample the bus driver mid-bit while it is enabled
  initial
    forever
    begin
      @(negedge txd);
      if (de_act)
      begin
        repeat (BIT_CLKS / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CLKS) @(posedge aclk);
          sh[i] = txd;
        end
        got.push_back(sh);
      end
    end
endmodule

// ==== verification/uart_de_irq_checker.sv ====
// assertion checker for the uart drive enable and interrupt block
`timescale 1ns/10ps
`include "uart_de_irq_consts.vh"
module uart_de_irq_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        txd,
  input wire        transceiver_drive_enable,
  input wire        tx_irq,
  input wire        rx_irq
);
  localparam int BIT_CLKS = 64; // baud reset value 4, 16 ticks a bit
  reg  [3:0]  aw_idx;
  reg  [31:0] wd;
  reg         txen;
  reg         pol;
  reg         started;
  reg  [7:0]  de_cnt;
  reg  [7:0]  hi_cnt;
  wire        de_act  = transceiver_drive_enable ^ pol;
  wire        wr_done = s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY;

  // shadow of enable and polarity bits, lead and tail counters of the frame
  always @(posedge aclk)
    if (!aresetn)
    begin
      txen    <= 1'b0;
      pol     <= 1'b0;
      started <= 1'b0;
      de_cnt  <= 8'h00;
      hi_cnt  <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_idx <= s_axi_awaddr[5:2];
      if (s_axi_wvalid && s_axi_wready)
        wd <= s_axi_wdata;
      if (wr_done && aw_idx == `ADDR_CTL0)
        txen <= wd[`CTL0_TXEN];
      if (wr_done && aw_idx == `ADDR_CTL1)
        pol <= wd[`CTL1_DRIVE_ENABLE_POLARITY];
      started <= de_act && (started || !txd);
      de_cnt  <= de_act ? de_cnt + {7'h00, de_cnt != 8'hff} : 8'h00;
      hi_cnt  <= (de_act && txd) ? hi_cnt + {7'h00, hi_cnt != 8'hff} : 8'h00;
    end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_frame_enveloped: assert property (!txd |-> de_act)
    else $error("txd low without drive enable");
  a_de_on_write: assert property (wr_done && aw_idx == `ADDR_TXD && txen |-> ##[0:2] de_act)
    else $error("drive enable missing after write");
  a_de_lead_time: assert property (de_act && !txd && !started |->
    de_cnt >= BIT_CLKS - 1 && de_cnt <= 2 * BIT_CLKS + 1)
    else $error("drive enable lead out of range");
  a_de_release: assert property ($fell(de_act) && $past(started) |->
    $past(hi_cnt) >= BIT_CLKS - 2)
    else $error("drive enable dropped before stop end");
  a_empty_clears: assert property (wr_done && aw_idx == `ADDR_TXD && txen |-> ##[0:3] !tx_irq)
    else $error("tx interrupt stays after write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer withdrawn");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  a_ro_write_refused: assert property (s_axi_bvalid && (aw_idx == `ADDR_RXD ||
    aw_idx == `ADDR_STAT0 || aw_idx == `ADDR_STAT1) |-> s_axi_bresp == `RESP_SLVERR)
    else $error("read-only write accepted");

  c_frame_done: cover property ($fell(de_act) && $past(started));
  c_rx_event: cover property ($rose(rx_irq));
  c_tx_event: cover property ($rose(tx_irq) && txen);
endmodule

bind uart_driver_enable_and_irq uart_de_irq_checker uart_de_irq_checker_inst (.*);

// ==== verification/uart_driver_enable_and_irq_bench.sv ====
// self-checking bench for the uart drive enable and interrupt block
`timescale 1ns/10ps
`include "uart_de_irq_consts.vh"
module uart_driver_enable_and_irq_bench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        pol = 1'b0;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, rxd, txd, de, tx_irq, rx_irq;
  wire         de_act = de ^ pol;
  logic        de_q = 1'b0;
  int          fail_count = 0, n_checks = 0, drops = 0, n;
  logic [33:0] exp_q[$];
  logic [31:0] mask_q[$];
  logic [7:0]  b, d0, d1;
  logic [31:0] m;

  always #2.5 aclk = ~aclk;

  uart_driver_enable_and_irq uart_driver_enable_and_irq_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxd(rxd), .txd(txd), .transceiver_drive_enable(de), .tx_irq(tx_irq), .rx_irq(rx_irq));

  line_partner line_partner_inst (.aclk(aclk), .txd(txd), .de_act(de_act), .rxd(rxd));

  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // bus answers are compared against the oldest noted expectation
  always @(posedge aclk)
  begin
    de_q <= de_act;
    if (de_q && !de_act)
      drops++;
    if (bvalid && bready)
    begin
      m = mask_q.pop_front();
      check({bresp, 32'h0000_0000}, exp_q.pop_front());
    end
    if (rvalid && rready)
    begin
      m = mask_q.pop_front();
      check({rresp, rdata & m}, exp_q.pop_front());
    end
  end

  // software waits for the holding register to empty before the next byte
  task automatic wait_tx_empty;
    int t;
    for (t = 0; t < 300; t++)
    begin
      @(posedge aclk);
      if (tx_irq)
        break;
    end
    if (t == 300)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] d, input logic [1:0] rsp);
    int t;
    @(posedge aclk);
    exp_q.push_back({rsp, 32'h0000_0000});
    mask_q.push_back(32'h0000_0000);
    awaddr <= {26'h000_0000, idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (t == 100)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] rsp = `RESP_OKAY);
    int t;
    @(posedge aclk);
    exp_q.push_back({rsp, d & m});
    mask_q.push_back(m);
    araddr <= {26'h000_0000, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 100; t++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (t == 100)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // main sequence
  initial
  begin
    b = $urandom(32'h1c9c);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_CTL1, 32'h0000_0000, 32'h0000_001f);
    rd(`ADDR_BRG, 32'h0000_0004, 32'h0000_ffff);
    rd(4'h7, 32'h0000_0000, 32'h0000_0000, `RESP_SLVERR);
    wr(`ADDR_STAT0, 32'h0000_0000, `RESP_SLVERR);
    wr(`ADDR_CTL1, 32'h0000_0010, `RESP_OKAY);
    n = 0;
    repeat (40) @(posedge aclk) n += tx_irq;
    check(n, 10);
    wr(`ADDR_CTL1, 32'h0000_0000, `RESP_OKAY);
    wr(`ADDR_CTL0, 32'h0000_0003, `RESP_OKAY);
    b = $urandom;
    wr(`ADDR_TXD, {24'h00_0000, b}, `RESP_OKAY);
    rd(`ADDR_STAT0, 32'h0000_0000, 32'h0000_0020);
    repeat (210) @(posedge aclk);
    check({tx_irq, rx_irq}, 2'b10);
    repeat (600) @(posedge aclk);
    check(de, 1'b0);
    check(line_partner_inst.got.pop_front(), b);
    d0 = $urandom;
    d1 = $urandom;
    n = drops;
    wr(`ADDR_TXD, {24'h00_0000, d0}, `RESP_OKAY);
    wait_tx_empty();
    wr(`ADDR_TXD, {24'h00_0000, d1}, `RESP_OKAY);
    repeat (1700) @(posedge aclk);
    check(drops - n, 1);
    check(line_partner_inst.got.pop_front(), d0);
    check(line_partner_inst.got.pop_front(), d1);
    wr(`ADDR_CTL1, 32'h0000_0004, `RESP_OKAY);
    pol <= 1'b1;
    repeat (3) @(posedge aclk);
    check(de, 1'b1);
    wr(`ADDR_TXD, {24'h00_0000, b}, `RESP_OKAY);
    repeat (900) @(posedge aclk);
    check({de, line_partner_inst.got.pop_front()}, {1'b1, b});
    wr(`ADDR_CTL1, 32'h0000_0000, `RESP_OKAY);
    pol <= 1'b0;
    line_partner_inst.send(b, 1'b0, 1'b0, 1'b1);
    check(rx_irq, 1'b1);
    rd(`ADDR_STAT0, 32'h0000_0001, 32'h0000_001f);
    rd(`ADDR_RXD, {24'h00_0000, b}, 32'h0000_00ff);
    repeat (3) @(posedge aclk);
    check(rx_irq, 1'b0);
    line_partner_inst.send(d0, 1'b0, 1'b0, 1'b1);
    line_partner_inst.send(d1, 1'b0, 1'b0, 1'b1);
    rd(`ADDR_STAT0, 32'h0000_0001, 32'h0000_001f);
    rd(`ADDR_RXD, {24'h00_0000, d0}, 32'h0000_00ff);
    rd(`ADDR_STAT0, 32'h0000_0005, 32'h0000_001f);
    rd(`ADDR_RXD, 32'h0000_0000, 32'h0000_0000);
    rd(`ADDR_STAT0, 32'h0000_0000, 32'h0000_001f);
    wr(`ADDR_CTL1, 32'h0000_0008, `RESP_OKAY);
    line_partner_inst.send(b, 1'b0, 1'b0, 1'b1);
    check(rx_irq, 1'b0);
    rd(`ADDR_RXD, {24'h00_0000, b}, 32'h0000_00ff);
    line_partner_inst.send(b | 8'h01, 1'b0, 1'b0, 1'b0);
    check(rx_irq, 1'b1);
    rd(`ADDR_STAT0, 32'h0000_0008, 32'h0000_0008);
    rd(`ADDR_RXD, 32'h0000_0000, 32'h0000_0000);
    wr(`ADDR_CTL0, 32'h0000_0007, `RESP_OKAY);
    wr(`ADDR_CTL1, 32'h0000_0003, `RESP_OKAY);
    line_partner_inst.send(d0, 1'b1, ^d0, 1'b1);
    check(rx_irq, 1'b0);
    rd(`ADDR_RXD, 32'h0000_0000, 32'h0000_0000);
    line_partner_inst.send(d1, 1'b1, ~^d1, 1'b1);
    check(rx_irq, 1'b1);
    rd(`ADDR_STAT0, 32'h0000_0080, 32'h0000_0080);
    report_and_stop();
  end
endmodule
